// File: link_event_pkg.sv
// Operation
// - bit 7 reports last received message kind
// - bit 6 sets on transmit message begin
// - bit 5 sets on receive message begin
// - bit 4 sets on transmit message done
// - bit 3 sets on receive message done
// - bit 2 sets on frame check failure
// - bit 1 sets on seven ones received
// - bit 0 sets on 0x7e flag received
// - event bits stick until a status read or a clear register write clears them
// - enable bits gate events onto interrupt
package link_event_pkg;
  // byte address width: channel nibble, 12-bit index, two lane bits
  localparam int ADDR_W = 18;
  // register indexes within a channel; byte address is four times these
  localparam logic [11:0] STATUS_IDX = 12'hb16;
  localparam logic [11:0] ENABLE_IDX = 12'hb17;
  localparam logic [11:0] CLEAR_IDX = 12'hb18;
  // bit positions in the status register
  localparam int KIND_BIT = 7;
  localparam int TX_BEGIN_BIT = 6;
  localparam int RX_BEGIN_BIT = 5;
  localparam int TX_DONE_BIT = 4;
  localparam int RX_DONE_BIT = 3;
  localparam int CHECK_FAIL_BIT = 2;
  localparam int ABORT_BIT = 1;
  localparam int FLAG_BIT = 0;
  // number of sticky event bits
  localparam int EVT_W = 7;
  // values after reset
  localparam logic [6:0] EVENTS_RST = 7'h00;
  localparam logic [6:0] ENABLE_RST = 7'h00;
  localparam logic KIND_RST = 1'b0;
  localparam logic [2:0] ONES_RST = 3'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  // link patterns
  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [2:0] ABORT_ONES = 3'h7;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;
endpackage : link_event_pkg

// File: hdlc2_link_event_status.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
module hdlc2_link_event_status #(
  parameter logic [3:0] CHANNEL = 4'h0 // channel nibble of the register address
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [link_event_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // message controller event pulses
  input wire logic tx_msg_begin,
  input wire logic rx_msg_begin,
  input wire logic tx_msg_done,
  input wire logic rx_msg_done,
  input wire logic frame_check_fail,
  input wire logic message_kind_flag,
  // received link bits
  input wire logic rx_link_bit,
  input wire logic rx_link_bit_valid,
  // interrupt
  output logic irq
);

  // register address compare, channel nibble included
  function automatic logic reg_hit(input logic [link_event_pkg::ADDR_W-1:0] addr,
                                   input logic [11:0] idx);
    reg_hit = (addr == {CHANNEL, idx, 2'b00});
  endfunction : reg_hit

  // bus state
  link_event_pkg::bus_state_e bus_state_reg;
  link_event_pkg::bus_state_e bus_state_next;
  logic waitrequest_reg; // registered wait flag
  logic waitrequest_next;
  logic [31:0] readdata_reg; // snapshot taken at request
  logic [31:0] readdata_next;
  logic rd_accept; // read completes at this edge
  logic wr_accept; // write completes at this edge

  // link pattern detectors
  logic [2:0] ones_cnt_reg; // run of ones, saturating
  logic [2:0] ones_cnt_next;
  logic [7:0] flag_shift_reg; // last eight link bits
  logic [7:0] flag_shift_next;
  logic abort_pulse; // seventh one of a run
  logic flag_pulse; // flag octet completed

  // status, enable and interrupt
  logic [6:0] events_reg; // sticky event bits
  logic [6:0] events_next;
  logic kind_reg; // kind of last received message
  logic kind_next;
  logic [6:0] enable_reg; // per-event interrupt enable
  logic [6:0] enable_next;
  logic irq_reg;
  logic irq_next;
  logic [6:0] ev_vec; // this cycle's events, status layout
  logic [6:0] clr_vec; // bits to clear this cycle

  // outputs straight from flops
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign irq = irq_reg;

  // one wait cycle, then a one-cycle answer; keeps decode off the bus path
  always_comb
  begin
    bus_state_next = bus_state_reg;
    waitrequest_next = waitrequest_reg;
    readdata_next = readdata_reg;
    rd_accept = 1'b0;
    wr_accept = 1'b0;
    case (bus_state_reg)
      link_event_pkg::BUS_IDLE:
      begin
        // request seen: capture the read value now
        if (avs_read || avs_write)
        begin
          bus_state_next = link_event_pkg::BUS_ACK;
          waitrequest_next = 1'b0;
          if (!avs_read)
          begin
            readdata_next = 32'h00000000;
          end
          else if (reg_hit(avs_address, link_event_pkg::STATUS_IDX))
          begin
            readdata_next = {24'h000000, kind_reg, events_reg};
          end
          else if (reg_hit(avs_address, link_event_pkg::ENABLE_IDX))
          begin
            readdata_next = {25'h0000000, enable_reg};
          end
          else
          begin
            // clear register and unmapped addresses read zero
            readdata_next = 32'h00000000;
          end
        end
      end
      link_event_pkg::BUS_ACK:
      begin
        // master holds the request until this edge
        rd_accept = avs_read;
        wr_accept = avs_write;
        bus_state_next = link_event_pkg::BUS_IDLE;
        waitrequest_next = 1'b1;
      end
      default:
      begin
        bus_state_next = link_event_pkg::BUS_IDLE;
        waitrequest_next = 1'b1;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_state_reg <= link_event_pkg::BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  // abort and flag detection on the incoming link bits
  always_comb
  begin
    ones_cnt_next = ones_cnt_reg;
    flag_shift_next = flag_shift_reg;
    abort_pulse = 1'b0;
    flag_pulse = 1'b0;
    if (rx_link_bit_valid)
    begin
      // the flag octet is a palindrome, so shift direction does not matter
      flag_shift_next = {flag_shift_reg[6:0], rx_link_bit};
      flag_pulse = (flag_shift_next == link_event_pkg::FLAG_OCTET);
      if (rx_link_bit)
      begin
        // one pulse per run, however long the run lasts
        if (ones_cnt_reg != link_event_pkg::ABORT_ONES)
        begin
          ones_cnt_next = ones_cnt_reg + 3'h1;
        end
        abort_pulse = (ones_cnt_reg == (link_event_pkg::ABORT_ONES - 3'h1));
      end
      else
      begin
        ones_cnt_next = link_event_pkg::ONES_RST;
      end
    end
  end

  // detector registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ones_cnt_reg <= link_event_pkg::ONES_RST;
      flag_shift_reg <= link_event_pkg::SHIFT_RST;
    end
    else
    begin
      ones_cnt_reg <= ones_cnt_next;
      flag_shift_reg <= flag_shift_next;
    end
  end

  // sticky events, kind latch, enable and interrupt
  always_comb
  begin
    ev_vec = {tx_msg_begin, rx_msg_begin, tx_msg_done, rx_msg_done,
              frame_check_fail, abort_pulse, flag_pulse};
    clr_vec = 7'h00;
    // clear only what the read returned, so late events survive
    if (rd_accept && reg_hit(avs_address, link_event_pkg::STATUS_IDX))
    begin
      clr_vec = readdata_reg[6:0];
    end
    else if (wr_accept && avs_byteenable[0] && reg_hit(avs_address, link_event_pkg::CLEAR_IDX))
    begin
      clr_vec = avs_writedata[6:0];
    end
    // set wins over clear
    events_next = (events_reg & ~clr_vec) | ev_vec;
    kind_next = rx_msg_done ? message_kind_flag : kind_reg;
    enable_next = enable_reg;
    if (wr_accept && avs_byteenable[0] && reg_hit(avs_address, link_event_pkg::ENABLE_IDX))
    begin
      enable_next = avs_writedata[6:0];
    end
    irq_next = |(events_reg & enable_reg);
  end

  // status registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      events_reg <= link_event_pkg::EVENTS_RST;
      kind_reg <= link_event_pkg::KIND_RST;
      enable_reg <= link_event_pkg::ENABLE_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      events_reg <= events_next;
      kind_reg <= kind_next;
      enable_reg <= enable_next;
      irq_reg <= irq_next;
    end
  end

  // checks
  logic status_rd_acc; // clearing read of the status register
  assign status_rd_acc = rd_accept && reg_hit(avs_address, link_event_pkg::STATUS_IDX);

  sequence s_request_idle;
    (avs_read || avs_write) && bus_state_reg == link_event_pkg::BUS_IDLE;
  endsequence

  sequence s_answer_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_answer;
    @(posedge clk_sys) disable iff (!rst_b)
    s_request_idle |=> s_answer_once;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

  property p_kind_latch;
    @(posedge clk_sys) disable iff (!rst_b)
    rx_msg_done |=> kind_reg == $past(message_kind_flag);
  endproperty
  a_kind_latch: assert property (p_kind_latch) else $error("message kind not latched");

  property p_tx_begin;
    @(posedge clk_sys) disable iff (!rst_b)
    tx_msg_begin |=> events_reg[link_event_pkg::TX_BEGIN_BIT];
  endproperty
  a_tx_begin: assert property (p_tx_begin) else $error("tx begin not latched");

  property p_rx_begin;
    @(posedge clk_sys) disable iff (!rst_b)
    rx_msg_begin |=> events_reg[link_event_pkg::RX_BEGIN_BIT];
  endproperty
  a_rx_begin: assert property (p_rx_begin) else $error("rx begin not latched");

  property p_tx_done;
    @(posedge clk_sys) disable iff (!rst_b)
    tx_msg_done |=> events_reg[link_event_pkg::TX_DONE_BIT];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done not latched");

  property p_rx_done;
    @(posedge clk_sys) disable iff (!rst_b)
    rx_msg_done |=> events_reg[link_event_pkg::RX_DONE_BIT];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx done not latched");

  property p_check_fail;
    @(posedge clk_sys) disable iff (!rst_b)
    frame_check_fail |=> events_reg[link_event_pkg::CHECK_FAIL_BIT];
  endproperty
  a_check_fail: assert property (p_check_fail) else $error("check fail not latched");

  property p_abort;
    @(posedge clk_sys) disable iff (!rst_b)
    rx_link_bit_valid && rx_link_bit && ones_cnt_reg == 3'h6
      |=> events_reg[link_event_pkg::ABORT_BIT];
  endproperty
  a_abort: assert property (p_abort) else $error("abort not latched");

  property p_flag;
    @(posedge clk_sys) disable iff (!rst_b)
    rx_link_bit_valid && {flag_shift_reg[6:0], rx_link_bit} == 8'h7e
      |=> events_reg[link_event_pkg::FLAG_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("flag octet not latched");

  property p_read_clears;
    @(posedge clk_sys) disable iff (!rst_b)
    status_rd_acc && ev_vec == 7'h00 |=> (events_reg & $past(readdata_reg[6:0])) == 7'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_sticky;
    @(posedge clk_sys) disable iff (!rst_b)
    clr_vec == 7'h00 |=> (events_reg & $past(events_reg)) == $past(events_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event bit dropped");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (!rst_b)
    ##1 irq == |($past(events_reg) & $past(enable_reg));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rst_b)
    status_rd_acc && ev_vec != 7'h00 |=> (events_reg & $past(ev_vec)) == $past(ev_vec);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

endmodule : hdlc2_link_event_status

// File: hdlc2_link_event_status_tb_top.sv
`timescale 1ns/1ns
module hdlc2_link_event_status_tb_top;
  // channel nibble given to the design, non-zero so the decode is exercised
  localparam logic [3:0] CH = 4'h3;
  // clock and reset
  logic clk_sys;
  logic rst_b;
  // bus signals
  logic [link_event_pkg::ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // event pulses: tx begin, rx begin, tx done, rx done, check fail
  logic [4:0] evt;
  logic message_kind_flag;
  // received link bits
  logic rx_link_bit;
  logic rx_link_bit_valid;
  logic irq;
  // bookkeeping
  int error_cnt;
  int checks;
  logic [31:0] rd;

  hdlc2_link_event_status #(.CHANNEL(CH)) hdlc2_link_event_status_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_msg_begin(evt[0]), .rx_msg_begin(evt[1]), .tx_msg_done(evt[2]),
    .rx_msg_done(evt[3]), .frame_check_fail(evt[4]), .message_kind_flag(message_kind_flag),
    .rx_link_bit(rx_link_bit), .rx_link_bit_valid(rx_link_bit_valid), .irq(irq)
  );

  // 25 mhz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // one place where the run ends
  task automatic final_report();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // byte address of a register index in a given channel
  function automatic logic [17:0] adr(input logic [3:0] ch, input logic [11:0] idx);
    return {ch, idx, 2'b00};
  endfunction : adr

  // one bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // a hung slave ends the run
    if (n >= 50)
    begin
      error_cnt++;
      final_report();
    end
  endtask : bus

  // read a register of our channel and compare
  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, adr(CH, idx), 32'h0);
    chk(rd, exp);
  endtask : rdc

  // one-cycle pulse on a set of event inputs
  task automatic pulse(input logic [4:0] v);
    @(posedge clk_sys);
    evt <= v;
    @(posedge clk_sys);
    evt <= 5'h00;
  endtask : pulse

  // shift n link bits in, lowest first, one per cycle
  task automatic bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      rx_link_bit <= v[i];
      rx_link_bit_valid <= 1'b1;
    end
    @(posedge clk_sys);
    rx_link_bit_valid <= 1'b0;
    rx_link_bit <= ~rx_link_bit;
  endtask : bits

  // level of irq a few cycles after its cause
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  initial
  begin
    error_cnt = 0;
    checks = 0;
    rst_b = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    evt = 5'h00;
    message_kind_flag = 1'b0;
    rx_link_bit = 1'b0;
    rx_link_bit_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    // everything clear after reset
    rdc(link_event_pkg::STATUS_IDX, 32'h0);
    rdc(link_event_pkg::ENABLE_IDX, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // each pulse sets its own bit, sticks, and clears on read
    for (int i = 0; i < 5; i++)
    begin
      pulse(5'h01 << i);
      repeat (4) @(posedge clk_sys);
      rdc(link_event_pkg::STATUS_IDX, 32'h1 << (6 - i));
      rdc(link_event_pkg::STATUS_IDX, 32'h0);
    end
    // a returned bit whose event repeats at the clearing edge must survive the clear
    pulse(5'h04);
    fork
      rdc(link_event_pkg::STATUS_IDX, 32'h10);
      begin
        repeat (2) @(posedge clk_sys);
        evt <= 5'h04;
        @(posedge clk_sys);
        evt <= 5'h00;
      end
    join
    rdc(link_event_pkg::STATUS_IDX, 32'h10);
    // clear register drops only the written bits; other channel does not decode
    pulse(5'h11);
    bus(1'b1, adr(CH, link_event_pkg::CLEAR_IDX), 32'h04);
    bus(1'b0, adr(4'h0, link_event_pkg::STATUS_IDX), 32'h0);
    chk(rd, 32'h0);
    rdc(link_event_pkg::STATUS_IDX, 32'h40);
    // flag octet, whose six ones must not count as an abort
    bits(16'h007e, 8);
    rdc(link_event_pkg::STATUS_IDX, 32'h01);
    // seven ones in a row
    bits(16'h007f, 7);
    rdc(link_event_pkg::STATUS_IDX, 32'h02);
    // a zero starts a fresh run, then six ones only: nothing
    bits(16'h007e, 7);
    rdc(link_event_pkg::STATUS_IDX, 32'h00);
    // enabled event raises irq until the status read clears it
    bus(1'b1, adr(CH, link_event_pkg::ENABLE_IDX), 32'hff);
    rdc(link_event_pkg::ENABLE_IDX, 32'h7f);
    pulse(5'h02);
    irq_is(1'b1);
    rdc(link_event_pkg::STATUS_IDX, 32'h20);
    irq_is(1'b0);
    // disabled event stays latched but keeps irq low
    bus(1'b1, adr(CH, link_event_pkg::ENABLE_IDX), 32'h5f);
    pulse(5'h02);
    irq_is(1'b0);
    rdc(link_event_pkg::STATUS_IDX, 32'h20);
    // message kind follows the end of a received message and is not cleared by read
    message_kind_flag <= 1'b1;
    pulse(5'h08);
    message_kind_flag <= 1'b0;
    irq_is(1'b1);
    rdc(link_event_pkg::STATUS_IDX, 32'h88);
    bus(1'b1, adr(CH, link_event_pkg::STATUS_IDX), 32'h00);
    rdc(link_event_pkg::STATUS_IDX, 32'h80);
    pulse(5'h08);
    rdc(link_event_pkg::STATUS_IDX, 32'h08);
    final_report();
  end
endmodule : hdlc2_link_event_status_tb_top
